// ===== rtl/dual_timing_source.sv
// Purpose: Two redundant timing sections with elapsed-count code, OR-combined outputs.
// Assumes: Power commands and code lock are synchronous one-cycle or level inputs.
// Notes:   A full word FIFO holds the next code update back until one word is read out.
//
// Functional notes
// - Each power command turns its section on and the other section off; section one wins if both arrive together.
// - Every timing output is counted down from the single master clock.
// - Dividers are synchronous Johnson counters, one flip-flop changing per clock.
// - Phases come from different stages; other duty cycles from gated stages.
// - Each timing output ORs both sections and drives two identical copies.
// - The 24-bit code updates and is sent serially every quarter second.
// - Each readout shifts all 24 bits through a serial add-one and back.
// - A power command clears that section's code to zero, even if already on.
// - The maximum count wraps to zero on the next update and counting continues.
// - A dedicated square-wave reference goes to the multiplexer.
// - Transmitter-off pulse follows about 48.5 days of elapsed count.
// - Lock asserted before power-on yields the transmitter-off pulse quickly.
// - Each quarter second: rest interval, then envelope with 24 shift pulses.
// - Two flip-flops sample the top bit per update; both set gives one pulse.
// - Under lock, updates alternately fill the code with all ones and zeros.
// - Multiplexer reference is the master clock divided by four, then two.
`timescale 1ns/1ps
`default_nettype none
module dual_timing_source #(
	parameter int REST_CYC  = dual_timing_pkg::REST_CYC,
	parameter int PULSE_CYC = dual_timing_pkg::PULSE_CYC
) (
	input  wire logic                                mclk,
	input  wire logic                                rst_n,
	input  wire logic                                on_sec1_cmd,
	input  wire logic                                on_sec2_cmd,
	input  wire logic                                code_lock,
	output logic [dual_timing_pkg::TIM_W-1:0]        timing_a,
	output logic [dual_timing_pkg::TIM_W-1:0]        timing_b,
	output logic                                     mux_ref_out,
	output logic                                     code_nrz,
	output logic                                     code_shift_pulse,
	output logic                                     code_envelope,
	output logic                                     tx_off_pulse,
	output logic [1:0]                               section_powered,
	output logic [dual_timing_pkg::CODE_W-1:0]       code_word,
	output logic                                     code_valid,
	input  wire logic                                code_ready
);
	typedef struct packed {
		dual_timing_pkg::phase_e                phase;
		logic [dual_timing_pkg::CNT_W-1:0]      cnt;
		logic [dual_timing_pkg::BITS_W-1:0]     bits;
		logic [dual_timing_pkg::CODE_W-1:0]     code;
		logic [dual_timing_pkg::CODE_W-1:0]     snap;
		logic                                   carry;
		logic                                   fill;
		logic                                   dec_a;
		logic                                   dec_b;
		logic                                   tx;
		logic                                   tx_done;
		logic                                   shp;
		logic                                   pend;
		logic                                   all_lock;
		logic                                   no_lock;
	} sec_s;

	typedef struct packed {
		logic [1:0]                             power;
		sec_s [1:0]                             sec;
		logic [dual_timing_pkg::TIM_W-1:0]      tim;
		logic                                   multiplexer_reference_output;
		logic                                   nrz;
		logic                                   env;
		logic                                   shp;
		logic                                   tx;
	} top_s;

	top_s                                   st_reg;
	top_s                                   st_next;
	logic [1:0]                             cmd;
	logic [1:0]                             clr;
	logic [1:0]                             sum_bit;
	logic [1:0]                             upd;
	logic [1:0][dual_timing_pkg::DIV4_STAGES-1:0] d4;
	logic [1:0][dual_timing_pkg::DIV2_STAGES-1:0] d2;
	logic                                   fifo_in_ready;
	logic                                   fifo_in_valid;
	logic [dual_timing_pkg::CODE_W-1:0]     fifo_in_data;

	function automatic logic at_end(input logic [dual_timing_pkg::CNT_W-1:0] c, input int lim);
		at_end = (c == dual_timing_pkg::CNT_W'(lim - 1));
	endfunction

	assign cmd = {on_sec2_cmd, on_sec1_cmd};
	// A command also clears the section it turns off, so that section goes quiet at once.
	assign clr = ~st_reg.power | {2{|cmd}};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sec
			// Both dividers step on the common clock; the second advances once per div4 cycle.
			johnson_divider #(.STAGES(dual_timing_pkg::DIV4_STAGES)) u_div4 (
				.mclk  (mclk),
				.rst_n (rst_n),
				.clear (clr[gi]),
				.step  (1'b1),
				.q     (d4[gi])
			);
			johnson_divider #(.STAGES(dual_timing_pkg::DIV2_STAGES)) u_div2 (
				.mclk  (mclk),
				.rst_n (rst_n),
				.clear (clr[gi]),
				.step  (d4[gi] == dual_timing_pkg::DIV4_STEP_STATE),
				.q     (d2[gi])
			);
			assign upd[gi] = !clr[gi] && st_reg.sec[gi].phase == dual_timing_pkg::PH_BURST
				&& at_end(st_reg.sec[gi].cnt, PULSE_CYC)
				&& st_reg.sec[gi].bits == dual_timing_pkg::LAST_BIT;
		end
	endgenerate

	assign fifo_in_valid = |(st_reg.power & {st_reg.sec[1].pend, st_reg.sec[0].pend});
	assign fifo_in_data  = st_reg.power[1] ? st_reg.sec[1].code : st_reg.sec[0].code;

	always_comb begin
		st_next = st_reg;
		sum_bit = '0;
		if (on_sec1_cmd) begin
			st_next.power = 2'h1;
		end else if (on_sec2_cmd) begin
			st_next.power = 2'h2;
		end
		for (int i = 0; i < 2; i++) begin
			st_next.sec[i].shp = 1'b0;
			if (clr[i]) begin
				st_next.sec[i] = '0;
			end else begin
				case (st_reg.sec[i].phase)
					dual_timing_pkg::PH_REST: begin
						if (st_reg.sec[i].pend && fifo_in_ready) begin
							st_next.sec[i].pend = 1'b0;
						end
						// A word still waiting for FIFO room holds the rest interval open.
						if (!at_end(st_reg.sec[i].cnt, REST_CYC)) begin
							st_next.sec[i].cnt = st_reg.sec[i].cnt + 1'b1;
						end else if (!st_reg.sec[i].pend) begin
							st_next.sec[i].phase    = dual_timing_pkg::PH_BURST;
							st_next.sec[i].cnt      = '0;
							st_next.sec[i].bits     = '0;
							st_next.sec[i].carry    = 1'b1;
							st_next.sec[i].snap     = st_reg.sec[i].code;
							st_next.sec[i].all_lock = code_lock;
							st_next.sec[i].no_lock  = !code_lock;
						end
					end
					dual_timing_pkg::PH_BURST: begin
						st_next.sec[i].all_lock = st_reg.sec[i].all_lock && code_lock;
						st_next.sec[i].no_lock  = st_reg.sec[i].no_lock && !code_lock;
						if (!at_end(st_reg.sec[i].cnt, PULSE_CYC)) begin
							st_next.sec[i].cnt = st_reg.sec[i].cnt + 1'b1;
						end else begin
							st_next.sec[i].cnt  = '0;
							st_next.sec[i].shp  = 1'b1;
							st_next.sec[i].bits = st_reg.sec[i].bits + 1'b1;
							if (code_lock) begin
								sum_bit[i] = st_reg.sec[i].fill;
							end else begin
								sum_bit[i] = st_reg.sec[i].code[0] ^ st_reg.sec[i].carry;
							end
							st_next.sec[i].carry = st_reg.sec[i].code[0] & st_reg.sec[i].carry;
							// Carry out of the top bit is dropped, so the maximum wraps to zero.
							st_next.sec[i].code = {sum_bit[i], st_reg.sec[i].code[dual_timing_pkg::CODE_W-1:1]};
							if (upd[i]) begin
								st_next.sec[i].phase = dual_timing_pkg::PH_REST;
								st_next.sec[i].pend  = 1'b1;
								st_next.sec[i].fill  = !st_reg.sec[i].fill;
								st_next.sec[i].dec_a = st_reg.sec[i].dec_a | sum_bit[i];
								st_next.sec[i].dec_b = st_reg.sec[i].dec_b
									| (st_reg.sec[i].dec_a & !sum_bit[i]);
								st_next.sec[i].tx = st_next.sec[i].dec_a && st_next.sec[i].dec_b
									&& !st_reg.sec[i].tx_done;
								st_next.sec[i].tx_done = st_reg.sec[i].tx_done | st_next.sec[i].tx;
							end
						end
					end
					default: begin
						st_next.sec[i].phase = dual_timing_pkg::PH_REST;
					end
				endcase
			end
		end
		st_next.tim = '0;
		st_next.multiplexer_reference_output = 1'b0;
		st_next.nrz = 1'b0;
		st_next.env = 1'b0;
		st_next.shp = 1'b0;
		st_next.tx  = 1'b0;
		for (int i = 0; i < 2; i++) begin
			if (st_reg.power[i]) begin
				st_next.tim = st_next.tim | {d2[i][0], d4[i][0] & ~d4[i][1], d4[i][1], d4[i][0]};
				st_next.multiplexer_reference_output = st_next.multiplexer_reference_output | d2[i][0];
				st_next.nrz = st_next.nrz | st_reg.sec[i].code[0];
				st_next.env = st_next.env | (st_reg.sec[i].phase == dual_timing_pkg::PH_BURST);
				st_next.shp = st_next.shp | st_reg.sec[i].shp;
				st_next.tx  = st_next.tx | st_reg.sec[i].tx;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	word_fifo #(.WIDTH(dual_timing_pkg::CODE_W), .DEPTH(dual_timing_pkg::FIFO_DEPTH)) u_fifo (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in_data),
		.out_valid (code_valid),
		.out_ready (code_ready),
		.out_data  (code_word)
	);

	assign timing_a         = st_reg.tim;
	assign timing_b         = st_reg.tim;
	assign mux_ref_out      = st_reg.multiplexer_reference_output;
	assign code_nrz         = st_reg.nrz;
	assign code_shift_pulse = st_reg.shp;
	assign code_envelope    = st_reg.env;
	assign tx_off_pulse     = st_reg.tx;
	assign section_powered  = st_reg.power;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_update0;
		upd[0] && st_reg.sec[0].no_lock && !code_lock;
	endsequence
	sequence s_locked_update0;
		upd[0] && st_reg.sec[0].all_lock && code_lock;
	endsequence
	sequence s_mux_rise0;
		$rose(d2[0][0]) && !clr[0] ##1 (!clr[0])[*3];
	endsequence

	property p_one_powered;
		$onehot0(st_reg.power);
	endproperty
	a_one_powered: assert property (p_one_powered)
		else $error("Both sections powered at once.");

	property p_cmd_swap;
		on_sec2_cmd && !on_sec1_cmd |=> st_reg.power == 2'h2 && st_reg.sec[0] == '0
			&& st_reg.sec[1].code == '0;
	endproperty
	a_cmd_swap: assert property (p_cmd_swap)
		else $error("Second command did not power section two alone.");

	property p_clear;
		on_sec1_cmd |=> st_reg.sec[0].code == '0 && st_reg.sec[0].phase == dual_timing_pkg::PH_REST;
	endproperty
	a_clear: assert property (p_clear)
		else $error("Code not cleared by power command.");

	property p_copies;
		timing_a == timing_b;
	endproperty
	a_copies: assert property (p_copies)
		else $error("Output copies differ.");

	property p_quiet;
		!st_reg.power[1] |-> st_reg.sec[1] == '0 && d2[1] == '0;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("Unpowered section is not quiet.");

	property p_increment;
		s_update0 |=> st_reg.sec[0].code == dual_timing_pkg::CODE_W'(st_reg.sec[0].snap + 1'b1);
	endproperty
	a_increment: assert property (p_increment)
		else $error("Update did not add exactly one.");

	property p_lock_fill;
		s_locked_update0 |=> st_reg.sec[0].code == '0 || st_reg.sec[0].code == '1;
	endproperty
	a_lock_fill: assert property (p_lock_fill)
		else $error("Locked update is not a uniform fill.");

	property p_burst_len;
		$fell(st_reg.sec[0].phase) && st_reg.power[0] && !$past(clr[0])
			|-> st_reg.sec[0].bits == 5'h18;
	endproperty
	a_burst_len: assert property (p_burst_len)
		else $error("Envelope did not carry 24 shift pulses.");

	property p_txoff;
		$rose(st_reg.sec[0].tx) |-> st_reg.sec[0].dec_a && st_reg.sec[0].dec_b && st_reg.sec[0].tx_done;
	endproperty
	a_txoff: assert property (p_txoff)
		else $error("Transmitter-off pulse without both decoder flops set.");

	property p_mux_div;
		s_mux_rise0 |=> $fell(d2[0][0]);
	endproperty
	a_mux_div: assert property (p_mux_div)
		else $error("Multiplexer reference half period is not four clocks.");
endmodule // dual_timing_source
`default_nettype wire

// ===== rtl/dual_timing_pkg.sv
// Purpose: Shared constants and types for the dual redundant timing source.
// Assumes: mclk stands in for the crystal oscillator and runs at 40 MHz.
// Notes:   Long cycle counts are defaults for top-level parameters.
package dual_timing_pkg;
	localparam int MCLK_HZ     = 40_000_000;
	localparam int REST_MS     = 50;
	localparam int BURST_PPS   = 120;
	localparam int REST_CYC    = MCLK_HZ / 1000 * REST_MS;
	localparam int PULSE_CYC   = MCLK_HZ / BURST_PPS;
	localparam int CODE_W      = 24;
	localparam int CNT_W       = 24;
	localparam int BITS_W      = 5;
	localparam int DIV4_STAGES = 2;
	localparam int DIV2_STAGES = 1;
	localparam int TIM_W       = 4;
	localparam int FIFO_DEPTH  = 8;
	localparam logic [DIV4_STAGES-1:0] DIV4_STEP_STATE = 2'h2;
	localparam logic [BITS_W-1:0]      LAST_BIT        = 5'h17;

	typedef enum logic {
		PH_REST  = 1'b0,
		PH_BURST = 1'b1
	} phase_e;
endpackage

// ===== rtl/johnson_divider.sv
// Purpose: Synchronous Johnson counter stage chain.
// Assumes: All stages share mclk; step gates the advance.
// Notes:   Divides by twice the stage count.
`timescale 1ns/1ps
`default_nettype none
module johnson_divider #(
	parameter int STAGES = 2
) (
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              clear,
	input  wire logic              step,
	output logic [STAGES-1:0]      q
);
	typedef struct packed {
		logic [STAGES-1:0] q;
	} jc_s;

	jc_s st_reg;
	jc_s st_next;

	always_comb begin
		st_next = st_reg;
		if (clear) begin
			st_next.q = '0;
		end else if (step) begin
			st_next.q = STAGES'({st_reg.q, ~st_reg.q[STAGES-1]});
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.q;

	property p_single_change;
		@(posedge mclk) disable iff (!rst_n)
		!$past(clear) |-> $countones(st_reg.q ^ $past(st_reg.q)) <= 1;
	endproperty
	a_single_change: assert property (p_single_change)
		else $error("More than one Johnson stage changed in one clock.");
endmodule // johnson_divider
`default_nettype wire

// ===== rtl/word_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: Single clock.
// Notes:   Output data is read straight from the storage flops.
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wptr;
		logic [AW-1:0]               rptr;
		logic [AW:0]                 count;
	} fifo_s;

	fifo_s st_reg;
	fifo_s st_next;
	logic  push;
	logic  pop;

	assign in_ready  = (st_reg.count != (AW+1)'(DEPTH));
	assign out_valid = (st_reg.count != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = st_reg.mem[st_reg.rptr];

	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.mem[st_reg.wptr] = in_data;
			st_next.wptr = (st_reg.wptr == AW'(DEPTH - 1)) ? '0 : st_reg.wptr + 1'b1;
		end
		if (pop) begin
			st_next.rptr = (st_reg.rptr == AW'(DEPTH - 1)) ? '0 : st_reg.rptr + 1'b1;
		end
		if (push && !pop) begin
			st_next.count = st_reg.count + 1'b1;
		end else if (pop && !push) begin
			st_next.count = st_reg.count - 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule // word_fifo
`default_nettype wire

// ===== bench/timing_consumer.sv
// Purpose: Consumer model for the timing outputs and the code word stream.
// Assumes: Inputs are sampled on the rising edge of mclk.
// Notes:   Period checks pause after power commands, since dividers restart.
`timescale 1ns/1ps
`default_nettype none
module timing_consumer #(
	parameter int BURST_CYC = 96
) (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic [3:0]  timing_a,
	input  wire logic [3:0]  timing_b,
	input  wire logic        mux_ref_out,
	input  wire logic        code_shift_pulse,
	input  wire logic        code_envelope,
	input  wire logic [1:0]  section_powered,
	input  wire logic        pwr_cmd,
	input  wire logic [23:0] code_word,
	input  wire logic        code_valid,
	input  wire logic        hold_off,
	output logic             code_ready
);
	logic [23:0] words[$];
	int          bad;
	int          checks;
	int          per;
	int          pulses;
	int          env_hi;
	int          quiet;
	logic        ref_d;
	logic        env_d;
	bit          ok_ref;
	bit          ok_env;

	// A stalling consumer only lowers ready; it never drops a word.
	assign code_ready = !hold_off;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			per = 0; pulses = 0; env_hi = 0; quiet = 12;
			ref_d = 0; env_d = 0; ok_ref = 0; ok_env = 0;
		end else begin
			if (code_valid && code_ready) words.push_back(code_word);
			chk(timing_a, timing_b);
			if (section_powered === 2'h0) chk({timing_a, mux_ref_out}, 32'h0);
			if (pwr_cmd || section_powered === 2'h0) begin
				quiet = 12; ok_ref = 0; ok_env = 0;
			end else if (quiet > 0) quiet--;
			if (mux_ref_out && !ref_d) begin
				if (ok_ref) chk(per, 8);
				per = 0;
				ok_ref = (quiet == 0);
			end
			if (code_envelope && !env_d) begin
				if (ok_env) chk(pulses, 24);
				pulses = 0;
				env_hi = 0;
				ok_env = (quiet == 0);
			end
			if (!code_envelope && env_d && ok_env) chk(env_hi, BURST_CYC);
			per++;
			pulses += code_shift_pulse;
			if (code_envelope) env_hi++;
			ref_d = mux_ref_out;
			env_d = code_envelope;
		end
	end
endmodule // timing_consumer
`default_nettype wire

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for the dual redundant timing source.
// Assumes: Short rest and pulse parameters keep frames at 116 cycles.
// Notes:   Lock scenario releases lock just after an all-ones word.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int REST  = 20;
	localparam int PULSE = 4;
	localparam int FRAME = REST + 24 * PULSE;
	logic        mclk;
	logic        rst_n;
	logic        on1;
	logic        on2;
	logic        lock;
	logic        force_stall;
	logic        rnd_stall;
	logic        rnd_on;
	wire  logic  hold_off;
	wire  logic  code_ready;
	logic [3:0]  timing_a;
	logic [3:0]  timing_b;
	logic        mux_ref_out;
	logic        code_nrz;
	logic        code_shift_pulse;
	logic        code_envelope;
	logic        tx_off_pulse;
	logic [1:0]  section_powered;
	logic [23:0] code_word;
	logic        code_valid;
	logic [23:0] w;
	integer      seed = 32'hBED9;
	int          miscompares;
	int          check_count;
	int          n;
	int          i;

	assign hold_off = force_stall | rnd_stall;

	dual_timing_source #(.REST_CYC(REST), .PULSE_CYC(PULSE)) dual_timing_source_i (
		.mclk(mclk), .rst_n(rst_n), .on_sec1_cmd(on1), .on_sec2_cmd(on2),
		.code_lock(lock), .timing_a(timing_a), .timing_b(timing_b),
		.mux_ref_out(mux_ref_out), .code_nrz(code_nrz),
		.code_shift_pulse(code_shift_pulse), .code_envelope(code_envelope),
		.tx_off_pulse(tx_off_pulse), .section_powered(section_powered),
		.code_word(code_word), .code_valid(code_valid), .code_ready(code_ready)
	);

	timing_consumer #(.BURST_CYC(24 * PULSE)) sink_i (
		.mclk(mclk), .rst_n(rst_n), .timing_a(timing_a), .timing_b(timing_b),
		.mux_ref_out(mux_ref_out), .code_shift_pulse(code_shift_pulse),
		.code_envelope(code_envelope), .section_powered(section_powered),
		.pwr_cmd(on1 | on2), .code_word(code_word), .code_valid(code_valid),
		.hold_off(hold_off), .code_ready(code_ready)
	);

	task automatic tick(input int k);
		repeat (k) begin
			@(posedge mclk);
			#2;
		end
	endtask

	task automatic cmp_word(input logic [23:0] got, input logic [23:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_flag(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		miscompares += sink_i.bad;
		check_count += sink_i.checks;
		if (miscompares == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// The stall pattern is quietened first so that no older word survives the command.
	// The queue is emptied two clocks late, since a word pushed at the command edge still lands.
	task automatic power_cmd(input logic a, input logic b, input logic [1:0] exp);
		rnd_on = 0;
		tick(3);
		on1 = a;
		on2 = b;
		tick(1);
		on1 = 0;
		on2 = 0;
		cmp_flag({6'h00, section_powered}, {6'h00, exp});
		tick(2);
		sink_i.words.delete();
	endtask

	task automatic get_word(output logic [23:0] v);
		int k;
		k = 0;
		while (sink_i.words.size() == 0 && k < 3000) begin
			tick(1);
			k++;
		end
		v = '0;
		if (k >= 3000) begin
			miscompares++;
			test_done;
		end else begin
			v = sink_i.words.pop_front();
		end
	endtask

	// Serial code is taken LSB first: bit 0 as the envelope opens, then one bit per shift pulse.
	task automatic get_serial(output logic [23:0] v);
		int k;
		k = 0;
		v = '0;
		while (code_envelope !== 1'b1 && k < 300) begin
			tick(1);
			k++;
		end
		v[0] = code_nrz;
		for (int b = 1; b < 24; b++) begin
			tick(1);
			while (code_shift_pulse !== 1'b1 && k < 300) begin
				tick(1);
				k++;
			end
			v[b] = code_nrz;
		end
	endtask

	initial begin
		mclk = 0;
		forever #12.5 mclk = ~mclk;
	end

	initial begin
		rnd_stall = 0;
		forever begin
			@(posedge mclk);
			#2;
			rnd_stall = rnd_on && (($random(seed) & 3) == 0);
		end
	end

	initial begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		test_done;
	end

	initial begin
		rst_n = 0; on1 = 0; on2 = 0; lock = 0; force_stall = 0; rnd_on = 0;
		repeat (4) @(posedge mclk);
		#2 rst_n = 1;
		tick(1);
		cmp_flag({4'h0, section_powered, tx_off_pulse, code_valid}, 8'h00);
		power_cmd(1, 0, 2'h1);
		power_cmd(1, 1, 2'h1);
		power_cmd(0, 1, 2'h2);
		rnd_on = 1;
		for (i = 1; i <= 5; i++) begin
			get_word(w);
			cmp_word(w, 24'(i));
		end
		tick($random(seed) & 63);
		power_cmd(0, 1, 2'h2);
		rnd_on = 1;
		get_word(w);
		cmp_word(w, 24'h000001);
		force_stall = 1;
		tick(10 * FRAME + 50);
		cmp_flag({7'h00, code_valid}, 8'h01);
		force_stall = 0;
		for (i = 2; i <= 13; i++) begin
			get_word(w);
			cmp_word(w, 24'(i));
		end
		lock = 1;
		tick(1);
		power_cmd(1, 0, 2'h1);
		n = 0;
		while (tx_off_pulse !== 1'b1 && n < 8 * FRAME) begin
			tick(1);
			n++;
		end
		cmp_flag({7'h00, tx_off_pulse}, 8'h01);
		n = 0;
		while (tx_off_pulse === 1'b1 && n < 300) begin
			tick(1);
			n++;
		end
		cmp_flag(n[7:0], 8'(FRAME));
		i = 0;
		while (sink_i.words.size() > 0) begin
			w = sink_i.words.pop_front();
			cmp_word(w, i[0] ? 24'hFFFFFF : 24'h000000);
			i++;
		end
		do begin
			get_word(w);
			cmp_word(w, i[0] ? 24'hFFFFFF : 24'h000000);
			i++;
		end while (w !== 24'hFFFFFF && i < 12);
		lock = 0;
		get_word(w);
		cmp_word(w, 24'h000000);
		get_word(w);
		cmp_word(w, 24'h000001);
		get_serial(w);
		cmp_word(w, 24'h000001);
		test_done;
	end
endmodule // tb_top
`default_nettype wire
